// ==== count_pin_edge.sv ====
/*
  external count pin sampler and edge detector.
  assumes the pin is synchronous to clk; the first stage stands in for the
  transparent-high latch ahead of the sampling register.
*/
`timescale 1ns/100ps
module count_pin_edge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic stage_a_r;   // front stage, read only by stage_b_r
  logic stage_b_r;   // sampled level
  logic stage_c_r;   // previous sampled level

  // ------------------------------------------------------------
  // sampling
  // ------------------------------------------------------------
  // one sample per clock, taken whatever the pin direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_a_r <= 1'b0;
      stage_b_r <= 1'b0;
      stage_c_r <= 1'b0;
    end else begin
      stage_a_r <= pin; // RQ7 RQ17
      stage_b_r <= stage_a_r; // RQ9
      stage_c_r <= stage_b_r;
    end
  end

  // edge strobes, one cycle each
  assign rise  = stage_b_r && !stage_c_r; // RQ8
  assign fall  = !stage_b_r && stage_c_r; // RQ8
  assign level = stage_b_r;

  a_edge_single: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    rise |=> !rise)
    else $error("rising edge gave more than one pulse");

endmodule

// ==== prescale_divider.sv ====
/*
  free-running shared prescaler counter with one-cycle tap enables.
  assumes clr is a synchronous level from the control register.
*/
`timescale 1ns/100ps
module prescale_divider #(
  parameter int W = timer_prescale_pkg::DIV_W
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                clr,
  output logic [W-1:0]                             cnt,
  output logic [timer_prescale_pkg::N_TAPS-1:0]    tap
);

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // counts every cycle whatever the timers select; held at zero by clr
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0; // RQ6
    end else begin
      cnt <= cnt + 1'b1; // RQ3 RQ4
    end
  end

  // ------------------------------------------------------------
  // taps
  // ------------------------------------------------------------
  // a tap fires on the last count of its low field, once per divisor
  for (genvar i = 0; i < timer_prescale_pkg::N_TAPS; i++) begin : g_tap
    localparam logic [W-1:0] MASK = W'((1 << timer_prescale_pkg::TAP_BITS[i]) - 1);
    assign tap[i] = !clr && ((cnt & MASK) == MASK); // RQ2 RQ18
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_tap8_period: assert property (@(posedge clk) disable iff (!rst_n || clr) // RQ2
    tap[0] |=> !tap[0] [*7] ##1 tap[0])
    else $error("divide-by-8 tap not spaced by 8 cycles");

  a_clear_restart: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    clr ##1 !clr |-> cnt == '0 && tap == '0)
    else $error("divider not restarted from zero after clear");

endmodule

// ==== shared_timer_prescaler.sv ====
/*
  shared timer prescaler and clock source front end for two timers, with a
  classic wishbone slave holding the control and clock select registers.
  assumes one 250 MHz clock, count pins synchronous to it, and timers that
  advance on any clock where their count enable output is high.
*/
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module shared_timer_prescaler #(
  parameter int DIV_W = timer_prescale_pkg::DIV_W  // divider width
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // external count pins
  input  wire logic        EXT_COUNT_PIN0,
  input  wire logic        EXT_COUNT_PIN1,
  // count enables to the timers
  output logic             T0_COUNT_EN,
  output logic             T1_COUNT_EN
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic                                   ack_r;      // bus answer
  logic [31:0]                            rdat_r;     // read data
  logic [31:0]                            rdat_nxt;   // read data mux
  logic                                   acc;        // new request
  logic                                   wb_wr;      // write commit
  logic                                   hold_r;     // sync_hold_mode
  logic                                   psr_r;      // divider_reset_bit
  logic [timer_prescale_pkg::CS_W-1:0]    sel_r [2];  // clock_source_select
  logic [DIV_W-1:0]                       div_cnt;    // divider state
  logic [timer_prescale_pkg::N_TAPS-1:0]  tap;        // divider enables
  logic [1:0]                             pin;        // count pins
  logic [1:0]                             pin_lvl;    // sampled levels
  logic [1:0]                             pin_rise;   // rising strobes
  logic [1:0]                             pin_fall;   // falling strobes
  logic [1:0]                             cnt_en;     // count enables

  // ------------------------------------------------------------
  // source decode
  // ------------------------------------------------------------
  // picks one timer's count enable from its select code
  function automatic logic pick_count(
    input logic [2:0] cs,
    input logic [3:0] taps,
    input logic       rise,
    input logic       fall
  );
    logic en;
    en = 1'b0;
    case (cs)
      timer_prescale_pkg::CS_OFF: begin
        en = 1'b0;      // stopped
      end
      timer_prescale_pkg::CS_DIRECT: begin
        en = 1'b1;      // every cycle
      end
      timer_prescale_pkg::CS_DIV8: begin
        en = taps[0];
      end
      timer_prescale_pkg::CS_DIV64: begin
        en = taps[1];
      end
      timer_prescale_pkg::CS_DIV256: begin
        en = taps[2];
      end
      timer_prescale_pkg::CS_DIV1024: begin
        en = taps[3];
      end
      timer_prescale_pkg::CS_FALL: begin
        en = fall;      // undivided pin edge
      end
      timer_prescale_pkg::CS_RISE: begin
        en = rise;      // undivided pin edge
      end
      default: begin
        en = 1'b0;
      end
    endcase
    return en;
  endfunction

  // tests a byte address against a register offset
  function automatic logic hit(
    input logic [7:0] adr,
    input logic [7:0] ofs
  );
    return adr == ofs;
  endfunction

  // ------------------------------------------------------------
  // wishbone handshake
  // ------------------------------------------------------------
  // request is taken on the first cycle, answered the next
  assign acc   = CYC_I && STB_I && !ack_r;
  // writes land on the edge where the master sees ack
  assign wb_wr = CYC_I && STB_I && WE_I && ack_r;
  assign ACK_O = ack_r;
  assign DAT_O = rdat_r;

  // ack for one cycle, then drops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdat_nxt = '0;
    if (hit(ADR_I, timer_prescale_pkg::OFS_CTRL)) begin
      // bits 6..1 stay zero
      rdat_nxt[timer_prescale_pkg::HOLD_BIT] = hold_r; // RQ15
      rdat_nxt[timer_prescale_pkg::PSR_BIT]  = psr_r;
    end else if (hit(ADR_I, timer_prescale_pkg::OFS_SEL0)) begin
      rdat_nxt[2:0] = sel_r[0];
    end else if (hit(ADR_I, timer_prescale_pkg::OFS_SEL1)) begin
      rdat_nxt[2:0] = sel_r[1];
    end else if (hit(ADR_I, timer_prescale_pkg::OFS_STAT)) begin
      rdat_nxt[DIV_W-1:0] = div_cnt;
      rdat_nxt[timer_prescale_pkg::STAT_PIN_LSB +: 2] = pin_lvl;
    end else begin
      rdat_nxt = '0;     // unmapped
    end
  end

  // read data captured with the request
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdat_r <= '0;
    end else if (acc && !WE_I) begin
      rdat_r <= rdat_nxt;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // hold mode is a plain stored bit
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hold_r <= timer_prescale_pkg::HOLD_RST;
    end else if (wb_wr && SEL_I[0] && hit(ADR_I, timer_prescale_pkg::OFS_CTRL)) begin
      hold_r <= DAT_I[timer_prescale_pkg::HOLD_BIT]; // RQ13
    end
  end

  // reset bit: kept while holding, else gone the next cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      psr_r <= timer_prescale_pkg::PSR_RST;
    end else if (wb_wr && SEL_I[0] && hit(ADR_I, timer_prescale_pkg::OFS_CTRL)) begin
      psr_r <= DAT_I[timer_prescale_pkg::PSR_BIT]; // RQ6
    end else if (!hold_r) begin
      psr_r <= 1'b0; // RQ6 RQ14
    end
  end

  // ------------------------------------------------------------
  // clock select registers
  // ------------------------------------------------------------
  // one select per timer, each written on its own offset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_r[0] <= timer_prescale_pkg::CS_RST;
      sel_r[1] <= timer_prescale_pkg::CS_RST;
    end else if (wb_wr && SEL_I[0]) begin
      if (hit(ADR_I, timer_prescale_pkg::OFS_SEL0)) begin
        sel_r[0] <= DAT_I[2:0]; // RQ5
      end
      if (hit(ADR_I, timer_prescale_pkg::OFS_SEL1)) begin
        sel_r[1] <= DAT_I[2:0]; // RQ5
      end
    end
  end

  // ------------------------------------------------------------
  // shared divider
  // ------------------------------------------------------------
  // a single instance feeds both timers
  prescale_divider #(
    .W     (DIV_W)
  ) u_div (
    .clk   (CLK),
    .rst_n (RESET_N),
    .clr   (psr_r),
    .cnt   (div_cnt),
    .tap   (tap)
  ); // RQ3

  // ------------------------------------------------------------
  // per-timer source
  // ------------------------------------------------------------
  assign pin = {EXT_COUNT_PIN1, EXT_COUNT_PIN0};

  // pin edge logic and select mux for each timer
  for (genvar t = 0; t < timer_prescale_pkg::N_TIMERS; t++) begin : g_timer
    count_pin_edge u_edge (
      .clk   (CLK),
      .rst_n (RESET_N),
      .pin   (pin[t]),
      .level (pin_lvl[t]),
      .rise  (pin_rise[t]),
      .fall  (pin_fall[t])
    ); // RQ7 RQ17
    // taps, direct clock or undivided pin edge
    assign cnt_en[t] = pick_count(sel_r[t], tap, pin_rise[t], pin_fall[t]); // RQ1 RQ12 RQ16
  end

  assign T0_COUNT_EN = cnt_en[0];
  assign T1_COUNT_EN = cnt_en[1];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // a control write that drops hold mode, then no further write
  sequence s_release;
    wb_wr && SEL_I[0] && hit(ADR_I, timer_prescale_pkg::OFS_CTRL)
      && !DAT_I[timer_prescale_pkg::HOLD_BIT] ##1 !wb_wr;
  endsequence

  // a read answer of the control register
  sequence s_ctrl_read;
    acc && !WE_I && hit(ADR_I, timer_prescale_pkg::OFS_CTRL) ##1 ack_r;
  endsequence

  a_stop_no_count: assert property ( // RQ16
    sel_r[0] == timer_prescale_pkg::CS_OFF |-> !T0_COUNT_EN)
    else $error("stopped timer received a count");

  a_direct_every_cycle: assert property ( // RQ1
    sel_r[1] == timer_prescale_pkg::CS_DIRECT |-> T1_COUNT_EN)
    else $error("direct source missed a cycle");

  a_ext_undivided: assert property ( // RQ12
    sel_r[0] == timer_prescale_pkg::CS_RISE
      |-> T0_COUNT_EN == (pin_lvl[0] && !$past(pin_lvl[0])))
    else $error("external edge not passed straight through");

  a_edge_latency: assert property ( // RQ9
    $rose(EXT_COUNT_PIN0) && sel_r[0] == timer_prescale_pkg::CS_RISE
      ##1 $stable(sel_r[0]) [*2] |-> T0_COUNT_EN)
    else $error("pin edge count not two cycles after sampling");

  a_reset_self_clear: assert property ( // RQ6
    psr_r && !hold_r && !wb_wr |=> !psr_r)
    else $error("divider reset bit not cleared by hardware");

  a_hold_keeps_reset: assert property ( // RQ13
    psr_r && hold_r && !wb_wr |=> psr_r && tap == '0)
    else $error("hold mode lost the divider reset");

  a_release_together: assert property ( // RQ14
    s_release |-> psr_r == $past(DAT_I[timer_prescale_pkg::PSR_BIT]) ##1 !psr_r)
    else $error("reset bit not cleared after leaving hold mode");

  a_reserved_zero: assert property ( // RQ15
    s_ctrl_read |-> DAT_O[6:1] == 6'h00)
    else $error("reserved control bits read nonzero");

  a_first_tap_bound: assert property ( // RQ4
    $rose(sel_r[0] == timer_prescale_pkg::CS_DIV8) && !psr_r
      |-> ##[0:8] T0_COUNT_EN)
    else $error("first divided count later than N+1 cycles");

  // a one-shot reset holds the divider for exactly one cycle
  a_one_shot_clear: assert property ( // RQ6
    s_release ##0 psr_r |=> !psr_r && div_cnt == '0)
    else $error("one-shot divider reset not a single cycle");

  // a select write lands on the ack edge and leaves the other timer alone
  a_select_write: assert property ( // RQ5
    wb_wr && SEL_I[0] && hit(ADR_I, timer_prescale_pkg::OFS_SEL0)
      |=> sel_r[0] == $past(DAT_I[2:0]) && $stable(sel_r[1]))
    else $error("timer 0 select write did not land alone");

  // timer 1 on the 64 tap follows the low six divider bits
  a_tap64_select: assert property ( // RQ2
    sel_r[1] == timer_prescale_pkg::CS_DIV64
      |-> T1_COUNT_EN == (!psr_r && div_cnt[5:0] == 6'h3f))
    else $error("divide-by-64 tap not where expected");

  // timer 1 on falling pin edges, rebuilt from the sampled level
  a_fall_undivided: assert property ( // RQ8
    sel_r[1] == timer_prescale_pkg::CS_FALL
      |-> T1_COUNT_EN == (!pin_lvl[1] && $past(pin_lvl[1])))
    else $error("falling pin edge not passed straight through");

  a_ack_one_cycle: assert property (
    ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

endmodule

// ==== test_shared_timer_prescaler.sv ====
/*
  self-checking bench for the shared timer prescaler: register access,
  tap timing, hold and release, pin edges, against a cycle model.
  assumes the package, the design and timer_pair_model compile first.
*/
`timescale 1ns/100ps
module test_shared_timer_prescaler;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        en0;
  logic        en1;
  logic        pin0;
  logic        pin1;
  logic        run0 = 1'b0;
  logic        run1 = 1'b0;
  logic        track = 1'b0;  // pin pulses expected
  logic        p0 = 1'b0;     // pin levels at last edge
  logic        p1 = 1'b0;
  logic [2:0]  code0 = 3'h0;  // selects last written
  logic [2:0]  code1 = 3'h0;
  logic [31:0] rd;            // last read data
  int          half0 = 2;
  int          half1 = 2;
  int          count0;
  int          count1;
  int          cyc = 0;       // current cycle index
  int          ack_at;        // cycle ended by last ack
  int          mismatches = 0;
  int          check_count = 0;
  int          n;
  int          div;
  int          e0[$];         // model pulse cycles
  int          e1[$];
  int          a0[$];         // seen pulse cycles
  int          a1[$];

  shared_timer_prescaler i_shared_timer_prescaler (
    .CLK(CLK), .RESET_N(RESET_N), .CYC_I(cyc_i), .STB_I(stb_i), .WE_I(we_i),
    .ADR_I(adr_i), .SEL_I(sel_i), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack_o),
    .EXT_COUNT_PIN0(pin0), .EXT_COUNT_PIN1(pin1), .T0_COUNT_EN(en0), .T1_COUNT_EN(en1)
  );
  timer_pair_model i_timer_pair_model (
    .clk(CLK), .rst_n(RESET_N), .en0(en0), .en1(en1), .run0(run0), .run1(run1),
    .half0(half0), .half1(half1), .pin0(pin0), .pin1(pin1), .count0(count0), .count1(count1)
  );

  always #2 CLK = ~CLK;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one classic cycle: raise after an edge, hold until ack, release
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    dat_i <= d;
    do @(posedge CLK); while (ack_o !== 1'b1);
    rd = dat_o;
    ack_at = cyc;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic clear_q();
    e0.delete();
    e1.delete();
    a0.delete();
    a1.delete();
  endtask

  // pulse log, pin edge model and cycle ceiling
  always @(posedge CLK) begin
    if (en0 === 1'b1) a0.push_back(cyc);
    if (en1 === 1'b1) a1.push_back(cyc);
    // bit 0 of the code picks the edge: set for rising
    if (track && pin0 !== p0 && pin0 === code0[0]) e0.push_back(cyc + 2);
    if (track && pin1 !== p1 && pin1 === code1[0]) e1.push_back(cyc + 2);
    p0 = pin0;
    p1 = pin1;
    cyc <= cyc + 1;
    if (cyc >= 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    n = $urandom(53044);
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    n = {timer_prescale_pkg::HOLD_RST, 6'h0, timer_prescale_pkg::PSR_RST};
    rd_check(timer_prescale_pkg::OFS_CTRL, n);
    rd_check(timer_prescale_pkg::OFS_SEL0, {29'h0, timer_prescale_pkg::CS_RST});
    check(count0 + count1, 0);
    // selects are kept per timer; lane 0 off drops a write
    n = $urandom;
    wb(1'b1, timer_prescale_pkg::OFS_SEL0, {29'h0, n[2:0]});
    wb(1'b1, timer_prescale_pkg::OFS_SEL1, {29'h0, ~n[2:0]});
    sel_i <= 4'he;
    wb(1'b1, timer_prescale_pkg::OFS_SEL0, 32'h0);
    sel_i <= 4'hf;
    rd_check(timer_prescale_pkg::OFS_SEL0, {29'h0, n[2:0]});
    rd_check(timer_prescale_pkg::OFS_SEL1, {29'h0, ~n[2:0]});
    wb(1'b1, 8'h10, 32'h81);
    rd_check(8'h10, 32'h0);
    // hold keeps the reset bit, divider parked at zero
    wb(1'b1, timer_prescale_pkg::OFS_CTRL, n | 32'h81);
    rd_check(timer_prescale_pkg::OFS_CTRL, 32'h81);
    wb(1'b0, timer_prescale_pkg::OFS_STAT, 32'h0);
    check(rd[9:0], 10'h0);
    // release from hold: taps restart together off one divider
    for (int c = 3; c <= 5; c++) begin
      div = 1 << timer_prescale_pkg::TAP_BITS[c - 2];
      wb(1'b1, timer_prescale_pkg::OFS_CTRL, 32'h81);
      wb(1'b1, timer_prescale_pkg::OFS_SEL0, {29'h0, timer_prescale_pkg::CS_DIV8});
      wb(1'b1, timer_prescale_pkg::OFS_SEL1, c);
      clear_q();
      repeat (1100) @(posedge CLK);
      check(a0.size() + a1.size(), 0);
      wb(1'b1, timer_prescale_pkg::OFS_CTRL, 32'h0);
      rd_check(timer_prescale_pkg::OFS_CTRL, 32'h0);
      repeat (2 * div + 20) @(posedge CLK);
      check(a1[0] - a0[0], div - 8);
      check(a1[1] - a1[0], div);
      check(a0[1] - a0[0], 8);
    end
    // tap enabled on a running divider counts within N+1 cycles
    wb(1'b1, timer_prescale_pkg::OFS_SEL1, 32'h0);
    for (int c = 2; c <= 5; c++) begin
      div = 1 << timer_prescale_pkg::TAP_BITS[c - 2];
      wb(1'b1, timer_prescale_pkg::OFS_SEL0, 32'h0);
      repeat (1 + $urandom % 97) @(posedge CLK);
      clear_q();
      wb(1'b1, timer_prescale_pkg::OFS_SEL0, c);
      repeat (div + 2) @(posedge CLK);
      check(a0[0] - ack_at >= 1 && a0[0] - ack_at <= div + 1, 1);
      check(a1.size(), 0);
    end
    // direct code counts every cycle, code zero none
    wb(1'b1, timer_prescale_pkg::OFS_SEL0, {29'h0, timer_prescale_pkg::CS_DIRECT});
    @(posedge CLK);
    n = count0;
    repeat (100) @(posedge CLK);
    check(count0 - n, 100);
    wb(1'b1, timer_prescale_pkg::OFS_SEL0, {29'h0, timer_prescale_pkg::CS_OFF});
    @(posedge CLK);
    n = count0;
    repeat (1100) @(posedge CLK);
    check(count0 - n, 0);
    // one-shot reset restarts the divider and clears itself
    repeat (1 + $urandom % 500) @(posedge CLK);
    wb(1'b1, timer_prescale_pkg::OFS_CTRL, 32'h1);
    wb(1'b0, timer_prescale_pkg::OFS_STAT, 32'h0);
    check(rd[9:0] < 10'h8, 1);
    rd_check(timer_prescale_pkg::OFS_CTRL, 32'h0);
    // pin edges pass undivided, rising or falling as chosen
    for (int k = 0; k < 2; k++) begin
      code0 = k ? timer_prescale_pkg::CS_FALL : timer_prescale_pkg::CS_RISE;
      code1 = k ? timer_prescale_pkg::CS_RISE : timer_prescale_pkg::CS_FALL;
      wb(1'b1, timer_prescale_pkg::OFS_SEL0, {29'h0, code0});
      wb(1'b1, timer_prescale_pkg::OFS_SEL1, {29'h0, code1});
      half0 = 2 + $urandom % 4;
      half1 = 2 + $urandom % 4;
      clear_q();
      track = 1'b1;
      run0 <= 1'b1;
      run1 <= 1'b1;
      repeat (200) @(posedge CLK);
      run0 <= 1'b0;
      run1 <= 1'b0;
      repeat (6) @(posedge CLK);
      track = 1'b0;
      check(a0.size(), e0.size());
      check(a1.size(), e1.size());
      foreach (e0[i]) check(a0[i], e0[i]);
      foreach (e1[i]) check(a1[i], e1[i]);
      wb(1'b0, timer_prescale_pkg::OFS_STAT, 32'h0);
      check(rd[timer_prescale_pkg::STAT_PIN_LSB +: 2], {pin1, pin0});
    end
    conclude();
  end
endmodule

// ==== timer_pair_model.sv ====
/*
  far side model: two timers that count on their enables, and two count
  pins that toggle at a set half period. assumes the bench clock.
*/
`timescale 1ns/100ps
module timer_pair_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en0,
  input  wire logic en1,
  input  wire logic run0,
  input  wire logic run1,
  input  int        half0,
  input  int        half1,
  output logic      pin0,
  output logic      pin1,
  output int        count0,
  output int        count1
);
  // ----------------------------------------
  // timers and pins
  // ----------------------------------------
  int tog0 = 0;  // cycles since pin 0 moved
  int tog1 = 0;  // cycles since pin 1 moved
  initial pin0 = 1'b0;
  initial pin1 = 1'b0;

  // timers advance on each edge with their enable high
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count0 <= 0;
      count1 <= 0;
    end else begin
      count0 <= count0 + int'(en0 === 1'b1);
      count1 <= count1 + int'(en1 === 1'b1);
    end
  end

  // pins stand still unless running, so selects change on a steady pin
  always @(posedge clk) begin
    if (!run0) tog0 <= 0;
    else if (tog0 + 1 >= (half0 < 2 ? 2 : half0)) begin
      pin0 <= ~pin0;
      tog0 <= 0;
    end else tog0 <= tog0 + 1;
    if (!run1) tog1 <= 0;
    else if (tog1 + 1 >= (half1 < 2 ? 2 : half1)) begin
      pin1 <= ~pin1;
      tog1 <= 0;
    end else tog1 <= tog1 + 1;
  end
endmodule

// ==== timer_prescale_pkg.sv ====
/*
  constants shared by the timer prescaler front end: register offsets, bit
  positions, reset values, clock source codes and divider tap layout.
  assumes a single 250 MHz clock and a 32-bit classic wishbone register bus.
*/
//
// Behaviour
// [RQ1] code 1 counts every system clock cycle
// [RQ2] taps at clock divided by 8/64/256/1024
// [RQ3] one free-running divider serves both timers
// [RQ4] first tap count within 1 to N+1 cycles
// [RQ5] each timer keeps its own tap selection
// [RQ6] reset bit clears divider, self-clears unless holding
// [RQ7] count pin sampled once per clock cycle
// [RQ8] one pulse per rising(7) or falling(6) edge
// [RQ9] counter updates 2.5 to 3.5 cycles after edge
// [RQ10] software switches pin source only when pin steady
// [RQ11] external clock below half system clock rate
// [RQ12] external pin edges are never divided
// [RQ13] hold mode keeps reset bit asserted
// [RQ14] clearing hold mode releases reset, timers restart together
// [RQ15] control bits 6 to 1 read zero
// [RQ16] code 0 gives no count clock
// [RQ17] pin counts even when configured as output
// [RQ18] 10-bit counter, taps are one-cycle enables
package timer_prescale_pkg;

  // ------------------------------------------------------------
  // bus layout
  // ------------------------------------------------------------
  localparam int          ADR_W       = 8;       // byte address width
  localparam logic [7:0]  OFS_CTRL    = 8'h00;   // timer_sync_control
  localparam logic [7:0]  OFS_SEL0    = 8'h04;   // timer 0 clock_source_select
  localparam logic [7:0]  OFS_SEL1    = 8'h08;   // timer 1 clock_source_select
  localparam logic [7:0]  OFS_STAT    = 8'h0c;   // divider count and pin levels

  // ------------------------------------------------------------
  // timer_sync_control fields
  // ------------------------------------------------------------
  localparam int          HOLD_BIT    = 7;       // sync_hold_mode
  localparam int          PSR_BIT     = 0;       // divider_reset_bit
  localparam logic        HOLD_RST    = 1'b0;    // hold mode after reset
  localparam logic        PSR_RST     = 1'b0;    // reset bit after reset

  // ------------------------------------------------------------
  // status fields
  // ------------------------------------------------------------
  localparam int          STAT_PIN_LSB = 16;     // synced pin levels

  // ------------------------------------------------------------
  // clock_source_select codes
  // ------------------------------------------------------------
  localparam int          CS_W        = 3;
  localparam logic [2:0]  CS_RST      = 3'h0;    // stopped after reset
  localparam logic [2:0]  CS_OFF      = 3'h0;
  localparam logic [2:0]  CS_DIRECT   = 3'h1;
  localparam logic [2:0]  CS_DIV8     = 3'h2;
  localparam logic [2:0]  CS_DIV64    = 3'h3;
  localparam logic [2:0]  CS_DIV256   = 3'h4;
  localparam logic [2:0]  CS_DIV1024  = 3'h5;
  localparam logic [2:0]  CS_FALL     = 3'h6;
  localparam logic [2:0]  CS_RISE     = 3'h7;

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  localparam int          DIV_W       = 10;      // free-running count width
  localparam int          N_TAPS      = 4;
  localparam int          TAP_BITS [N_TAPS] = '{3, 6, 8, 10};  // log2 of divisor
  localparam int          N_TIMERS    = 2;

endpackage
